/* hdl/pspg_cfg.svh */
// Purpose: constants of the port status page
// Assumes: 25 MHz clock, three cable ports
// Notes: offsets are register indices on a 5-bit address
`ifndef PSPG_CFG_SVH
`define PSPG_CFG_SVH
// ----------------------------------------
// offsets
// ----------------------------------------
`define PSPG_OFS_BASE7 5'h07
`define PSPG_OFS_LINE 5'h08
`define PSPG_OFS_CTRL 5'h09
`define PSPG_OFS_SPEED 5'h0A
`define PSPG_OFS_QUAL 5'h0B
`define PSPG_OFS_ERRS 5'h0C
`define PSPG_OFS_LOOP 5'h0D
`define PSPG_OFS_RSVE 5'h0E
`define PSPG_OFS_RSVF 5'h0F
`define PSPG_OFS_IRQ_STAT 5'h10
`define PSPG_OFS_IRQ_CLR 5'h11
`define PSPG_OFS_IRQ_EN 5'h12
// ----------------------------------------
// field positions (lsb numbering)
// ----------------------------------------
`define PSPG_BIT_TPA_HI 7
`define PSPG_BIT_TPA_LO 6
`define PSPG_BIT_TPB_HI 5
`define PSPG_BIT_TPB_LO 4
`define PSPG_BIT_ROLE 3
`define PSPG_BIT_ATT 2
`define PSPG_BIT_RXV 1
`define PSPG_BIT_DIS 0
`define PSPG_BIT_ALLOW 4
`define PSPG_BIT_WIRED 7
`define PSPG_BIT_PLUG 3
// ----------------------------------------
// reset values and sizes
// ----------------------------------------
`define PSPG_PORTS 4'h3
`define PSPG_PAGE_STATUS 3'h0
`define PSPG_RST_PAGE 3'h0
`define PSPG_RST_PORT 4'h0
`define PSPG_RST_DIS 3'h0
`define PSPG_RST_ALLOW 3'h0
`define PSPG_RST_IRQ_EN 6'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define PSPG_CLK_KHZ 25000
`define PSPG_CONN_DB_MS 341
`define PSPG_BIAS_DB_US 1
`define PSPG_CONN_DB_CYC (`PSPG_CONN_DB_MS * `PSPG_CLK_KHZ)
`define PSPG_BIAS_DB_CYC ((`PSPG_BIAS_DB_US * `PSPG_CLK_KHZ + 999) / 1000)
`endif

/* hdl/pspg_pkg.sv */
// Purpose: types of the port status page
// Assumes: nothing
// Notes: arbitration line codes
package pspg_pkg;
   typedef enum logic [1:0] {
      PSPG_ARB_INVALID = 2'h0,
      PSPG_ARB_ONE = 2'h1,
      PSPG_ARB_ZERO = 2'h2,
      PSPG_ARB_Z = 2'h3
   } pspg_arb_e;
   typedef logic [23:0] pspg_count_t;
endpackage : pspg_pkg

/* hdl/pspg_debounce.sv */
// Purpose: stability filter for one level
// Assumes: raw level synchronous to clk_in
// Notes: output rises after raw held high CYCLES cycles, falls at once
`timescale 1ns/1ns
module pspg_debounce
   import pspg_pkg::*;
#(
   parameter int unsigned CYCLES = 1
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic raw_in,
   output logic stable_out
);
   localparam pspg_count_t LIMIT = pspg_count_t'(CYCLES - 1);
   pspg_count_t cnt_r;

   // ----------------------------------------
   // counter
   // ----------------------------------------
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_r <= 24'h000000;
      end else if (!raw_in) begin
         cnt_r <= 24'h000000;
      end else if (cnt_r != LIMIT) begin
         cnt_r <= cnt_r + 24'h000001;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         stable_out <= 1'b0; // RULE8
      end else begin
         stable_out <= raw_in && (cnt_r == LIMIT); // RULE7
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   stable_wait_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE7
      $rose(stable_out) |-> $past(cnt_r) == LIMIT && $past(raw_in))
      else $error("filter output rose before the hold time");
   drop_fast_a: assert property (@(posedge clk_in) disable iff (rst_in)
      !raw_in |=> !stable_out)
      else $error("filter output held after raw level fell");
endmodule : pspg_debounce

/* hdl/pspg_top.sv */
// Purpose: per-port status page of a three-port cable physical layer
// Assumes: line comparators and connect detectors synchronous to clk_in
// Notes: read data stand only in the cycle after the read strobe
//
// Contract
// RULE1 - status page at indices 8..13, msb-first
// RULE2 - tpa field gives instantaneous arbitration code
// RULE3 - tpb field uses the same code
// RULE4 - tree role one for child, zero parent
// RULE5 - idle, disabled or suspended port reads child
// RULE6 - host ignores tree role until tree done
// RULE7 - attached rises after about 341 ms stable
// RULE8 - hardware reset clears attached; bus reset not
// RULE9 - newer style: tones plus speed negotiation connect
// RULE10 - host reads attached as physical connection only
// RULE11 - legacy receive valid is debounced cable bias
// RULE12 - beta receive valid is continuous valid signal
// RULE13 - beta tones alone keep receive valid low
// RULE14 - host selects page zero and port first
// RULE15 - unimplemented port reads all zero
// RULE16 - status reads have no side effects
//
// Implementation choice: strobed register access.
`timescale 1ns/1ns
`include "pspg_cfg.svh"
module pspg_top
   import pspg_pkg::*;
#(
   parameter int unsigned CONN_DB_CYCLES = `PSPG_CONN_DB_CYC
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [4:0] addr_in,
   input wire logic [7:0] wr_data_in,
   input wire logic wr_stb_in,
   input wire logic rd_stb_in,
   output logic [7:0] rd_data_out,
   output logic irq_out,
   output logic [2:0] port_disable_out,
   input wire logic bus_reset_in,
   input wire logic [2:0] tpa_pos_in,
   input wire logic [2:0] tpa_neg_in,
   input wire logic [2:0] tpb_pos_in,
   input wire logic [2:0] tpb_neg_in,
   input wire logic [2:0] child_in,
   input wire logic [2:0] suspended_in,
   input wire logic [2:0] beta_mode_in,
   input wire logic [2:0] wired_detect_in,
   input wire logic [2:0] tones_in,
   input wire logic [2:0] speed_done_in,
   input wire logic [2:0] cable_bias_in,
   input wire logic [2:0] signal_valid_in,
   input wire logic [8:0] neg_speed_in
);
   localparam int unsigned BIAS_DB_CYCLES = `PSPG_BIAS_DB_CYC;

   logic [2:0] page_sel_r;
   logic [3:0] port_sel_r;
   logic [2:0] allow_r;
   logic [2:0] attached;
   logic [2:0] bias_ok;
   logic [2:0] conn_raw;
   logic [2:0] tree_role;
   logic [2:0] rx_valid_r;
   logic [2:0] attached_q_r;
   logic [5:0] irq_stat_r;
   logic [5:0] irq_stat_nxt;
   logic [5:0] irq_en_r;
   logic [5:0] irq_en_nxt;
   logic [5:0] irq_set;
   logic [1:0] arb_a [3];
   logic [1:0] arb_b [3];
   logic [7:0] rd_nxt;
   logic [1:0] idx;
   logic port_ok;
   logic page_hit;
   logic wr_sel;

   // ----------------------------------------
   // line state encoding
   // ----------------------------------------
   function automatic pspg_arb_e arb_code(input logic pos, input logic neg);
      pspg_arb_e code;
      code = PSPG_ARB_INVALID;
      case ({pos, neg})
         2'b00: code = PSPG_ARB_Z;
         2'b10: code = PSPG_ARB_ONE;
         2'b01: code = PSPG_ARB_ZERO;
         default: code = PSPG_ARB_INVALID;
      endcase
      return code;
   endfunction : arb_code

   // ----------------------------------------
   // per-port status
   // ----------------------------------------
   for (genvar p = 0; p < 3; p++) begin : g_port
      assign arb_a[p] = arb_code(tpa_pos_in[p], tpa_neg_in[p]); // RULE2
      assign arb_b[p] = arb_code(tpb_pos_in[p], tpb_neg_in[p]); // RULE3
      assign conn_raw[p] = beta_mode_in[p] ?
         (tones_in[p] && speed_done_in[p]) : wired_detect_in[p]; // RULE9
      assign tree_role[p] = child_in[p] || !attached[p] ||
         port_disable_out[p] || suspended_in[p]; // RULE4 RULE5

      pspg_debounce #(
         .CYCLES(CONN_DB_CYCLES)
      ) u_conn_db (
         .clk_in(clk_in),
         .rst_in(rst_in),
         .raw_in(conn_raw[p]),
         .stable_out(attached[p])
      );

      pspg_debounce #(
         .CYCLES(BIAS_DB_CYCLES)
      ) u_bias_db (
         .clk_in(clk_in),
         .rst_in(rst_in),
         .raw_in(cable_bias_in[p]),
         .stable_out(bias_ok[p])
      );

      always_ff @(posedge clk_in or posedge rst_in) begin
         if (rst_in) begin
            rx_valid_r[p] <= 1'b0;
         end else if (beta_mode_in[p]) begin
            rx_valid_r[p] <= signal_valid_in[p]; // RULE12 RULE13
         end else begin
            rx_valid_r[p] <= bias_ok[p]; // RULE11
         end
      end

      beta_tone_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE13
         beta_mode_in[p] && tones_in[p] && !signal_valid_in[p] |=> !rx_valid_r[p])
         else $error("receive valid set on tones alone");
      legacy_rx_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE11
         !beta_mode_in[p] && !cable_bias_in[p] |=> ##1 !rx_valid_r[p])
         else $error("receive valid set without cable bias");
   end

   // ----------------------------------------
   // decode
   // ----------------------------------------
   assign idx = port_sel_r[1:0];
   assign port_ok = port_sel_r < `PSPG_PORTS; // RULE15
   assign page_hit = (page_sel_r == `PSPG_PAGE_STATUS) && port_ok; // RULE14
   assign wr_sel = wr_stb_in && page_hit;

   // ----------------------------------------
   // base register
   // ----------------------------------------
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         page_sel_r <= `PSPG_RST_PAGE;
         port_sel_r <= `PSPG_RST_PORT;
      end else if (wr_stb_in && addr_in == `PSPG_OFS_BASE7) begin
         page_sel_r <= wr_data_in[7:5];
         port_sel_r <= wr_data_in[3:0];
      end
   end

   // ----------------------------------------
   // per-port control bits
   // ----------------------------------------
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         port_disable_out <= `PSPG_RST_DIS;
      end else if (wr_sel && addr_in == `PSPG_OFS_LINE) begin
         port_disable_out[idx] <= wr_data_in[`PSPG_BIT_DIS];
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         allow_r <= `PSPG_RST_ALLOW;
      end else if (wr_sel && addr_in == `PSPG_OFS_CTRL) begin
         allow_r[idx] <= wr_data_in[`PSPG_BIT_ALLOW];
      end
   end

   // ----------------------------------------
   // port events and interrupt
   // ----------------------------------------
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         attached_q_r <= 3'h0;
      end else begin
         attached_q_r <= attached;
      end
   end

   assign irq_set = {allow_r & (attached ^ attached_q_r),
                     allow_r & (attached & ~attached_q_r)};

   always_comb begin
      irq_stat_nxt = irq_stat_r;
      if (wr_stb_in && addr_in == `PSPG_OFS_IRQ_CLR) begin
         irq_stat_nxt = irq_stat_nxt & ~wr_data_in[5:0];
      end
      irq_stat_nxt = irq_stat_nxt | irq_set;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_stat_r <= 6'h00;
      end else begin
         irq_stat_r <= irq_stat_nxt;
      end
   end

   always_comb begin
      irq_en_nxt = irq_en_r;
      if (wr_stb_in && addr_in == `PSPG_OFS_IRQ_EN) begin
         irq_en_nxt = wr_data_in[5:0];
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_en_r <= `PSPG_RST_IRQ_EN;
      end else begin
         irq_en_r <= irq_en_nxt;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(irq_stat_nxt & irq_en_nxt);
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   always_comb begin
      rd_nxt = 8'h00;
      case (addr_in)
         `PSPG_OFS_BASE7: begin
            rd_nxt = {page_sel_r, 1'b0, port_sel_r};
         end
         `PSPG_OFS_LINE: begin
            if (page_hit) begin // RULE15
               rd_nxt = {arb_a[idx], arb_b[idx], tree_role[idx], attached[idx],
                         rx_valid_r[idx], port_disable_out[idx]}; // RULE1
            end
         end
         `PSPG_OFS_CTRL: begin
            if (page_hit) begin
               rd_nxt = {neg_speed_in[3 * idx +: 3], allow_r[idx], 4'h0}; // RULE1
            end
         end
         `PSPG_OFS_SPEED: begin
            if (page_hit) begin
               rd_nxt[`PSPG_BIT_WIRED] = wired_detect_in[idx];
               rd_nxt[`PSPG_BIT_PLUG] = 1'b1;
            end
         end
         `PSPG_OFS_IRQ_STAT: begin
            rd_nxt = {2'h0, irq_stat_r};
         end
         `PSPG_OFS_IRQ_EN: begin
            rd_nxt = {2'h0, irq_en_r};
         end
         default: begin
            rd_nxt = 8'h00; // RULE1
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rd_data_out <= 8'h00;
      end else if (rd_stb_in) begin
         rd_data_out <= rd_nxt; // RULE16
      end else begin
         rd_data_out <= 8'h00;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   unimpl_zero_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE15
      rd_stb_in && addr_in[4:3] == 2'b01 && !port_ok |=> rd_data_out == 8'h00)
      else $error("unimplemented port read not zero");

   reserved_zero_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE1
      rd_stb_in && (addr_in == `PSPG_OFS_RSVE || addr_in == `PSPG_OFS_CTRL)
      |=> rd_data_out[0] == 1'b0 && (!$past(addr_in[2]) || rd_data_out == 8'h00))
      else $error("reserved or beta-exclusive bit not zero");

   tpa_code_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE2
      rd_stb_in && addr_in == `PSPG_OFS_LINE && page_hit && tpa_pos_in[idx] &&
      !tpa_neg_in[idx] |=> rd_data_out[7:6] == 2'b01)
      else $error("tpa one not coded 01");

   tpb_code_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE3
      rd_stb_in && addr_in == `PSPG_OFS_LINE && page_hit && !tpb_pos_in[idx] &&
      !tpb_neg_in[idx] |=> rd_data_out[5:4] == 2'b11)
      else $error("tpb z not coded 11");

   role_parent_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE4
      rd_stb_in && addr_in == `PSPG_OFS_LINE && page_hit && attached[idx] &&
      !port_disable_out[idx] && !suspended_in[idx] && !child_in[idx]
      |=> rd_data_out[3] == 1'b0)
      else $error("parent port not read as zero");

   role_child_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE5
      rd_stb_in && addr_in == `PSPG_OFS_LINE && page_hit &&
      (port_disable_out[idx] || suspended_in[idx] || !attached[idx])
      |=> rd_data_out[3] == 1'b1)
      else $error("idle port not read as child");

   bus_keep_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE8
      bus_reset_in && (conn_raw & attached) == attached
      |=> (attached & $past(attached)) == $past(attached))
      else $error("bus reset disturbed attached");

   read_quiet_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE16
      rd_stb_in |=> $stable(port_disable_out) && $stable(allow_r) && $stable(irq_en_r)
      && $stable(page_sel_r))
      else $error("read changed control state");

   irq_level_a: assert property (@(posedge clk_in) disable iff (rst_in)
      irq_out == |(irq_stat_r & irq_en_r))
      else $error("interrupt level disagrees with enabled status");

   irq_sticky_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (|irq_set) |=> (irq_stat_r & $past(irq_set)) == $past(irq_set))
      else $error("status event lost to a clear");

   tail_zero_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE1
      rd_stb_in && addr_in >= `PSPG_OFS_QUAL && addr_in <= `PSPG_OFS_RSVF
      |=> rd_data_out == 8'h00)
      else $error("unbuilt page byte not zero");

   plug_one_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE1
      rd_stb_in && addr_in == `PSPG_OFS_SPEED && page_hit |=> rd_data_out[3] == 1'b1)
      else $error("plug flag not read as one");

   field_read_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE1
      rd_stb_in && addr_in == `PSPG_OFS_LINE && page_hit
      |=> rd_data_out[2:1] == $past({attached[idx], rx_valid_r[idx]}))
      else $error("attached or receive valid misplaced");
endmodule : pspg_top

/* sim/pspg_link_model.sv */
// Purpose: link-layer controller model driving the register port
// Assumes: read data stand in the cycle after the read strobe
// Notes: idle write data shows the inverse of the last value
`timescale 1ns/1ns
`include "pspg_cfg.svh"
module pspg_link_model (
   input wire logic clk_in,
   input wire logic [7:0] rd_data_in,
   output logic [4:0] addr_out,
   output logic [7:0] wr_data_out,
   output logic wr_stb_out,
   output logic rd_stb_out
);
   // ----------------------------------------
   // bus cycles
   // ----------------------------------------
   initial begin
      addr_out = 5'h00;
      wr_data_out = 8'h00;
      wr_stb_out = 1'b0;
      rd_stb_out = 1'b0;
   end
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wr_data_out <= d;
      wr_stb_out <= 1'b1;
      @(posedge clk_in);
      wr_stb_out <= 1'b0;
      wr_data_out <= ~d;
   endtask : wr
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_stb_out <= 1'b1;
      @(posedge clk_in);
      rd_stb_out <= 1'b0;
      @(posedge clk_in);
      d = rd_data_in;
   endtask : rd
   // page and port chosen before any page access
   task automatic sel(input logic [2:0] page, input logic [3:0] port);
      wr(`PSPG_OFS_BASE7, {page, 1'b0, port});
   endtask : sel
endmodule : pspg_link_model

/* sim/tb_port_status_page.sv */
// Purpose: self-checking bench of the port status page
// Assumes: short connect debounce of 20 cycles
// Notes: one task per scenario
`timescale 1ns/1ns
`include "pspg_cfg.svh"
module tb_port_status_page;
   import pspg_pkg::*;
   logic clk_in = 1'b0, rst_in = 1'b1, bus_reset_in = 1'b0;
   logic [4:0] addr;
   logic [7:0] wdat, rdat, v;
   logic wr_stb, rd_stb, irq_out;
   logic [2:0] dis_out, tpa_p = 3'h0, tpa_n = 3'h0, tpb_p = 3'h0, tpb_n = 3'h0;
   logic [2:0] child = 3'h0, susp = 3'h0;
   logic [2:0] beta = 3'h0, wired = 3'h0, tones = 3'h0, spd = 3'h0, bias = 3'h0, sval = 3'h0;
   int bad_count = 0, total_checks = 0;
   // ----------------------------------------
   // clock, instances
   // ----------------------------------------
   initial begin
      forever #20 clk_in = ~clk_in;
   end
   pspg_link_model link (.clk_in(clk_in), .rd_data_in(rdat), .addr_out(addr),
      .wr_data_out(wdat), .wr_stb_out(wr_stb), .rd_stb_out(rd_stb));
   pspg_top #(.CONN_DB_CYCLES(20)) dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr),
      .wr_data_in(wdat), .wr_stb_in(wr_stb), .rd_stb_in(rd_stb), .rd_data_out(rdat),
      .irq_out(irq_out), .port_disable_out(dis_out), .bus_reset_in(bus_reset_in),
      .tpa_pos_in(tpa_p), .tpa_neg_in(tpa_n), .tpb_pos_in(tpb_p), .tpb_neg_in(tpb_n),
      .child_in(child), .suspended_in(susp), .beta_mode_in(beta), .wired_detect_in(wired),
      .tones_in(tones), .speed_done_in(spd), .cable_bias_in(bias), .signal_valid_in(sval),
      .neg_speed_in(9'h1AC));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask : cyc
   task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
      link.rd(a, v);
      chk(v, exp);
   endtask : rchk
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      rchk(`PSPG_OFS_BASE7, 8'h00);
      rchk(`PSPG_OFS_LINE, 8'hF8);
      @(posedge clk_in);
      chk(rdat, 8'h00);
      rchk(`PSPG_OFS_SPEED, 8'h08);
      rchk(`PSPG_OFS_RSVE, 8'h00);
      rchk(`PSPG_OFS_RSVF, 8'h00);
      rchk(5'h1F, 8'h00);
      $display("test reset done");
   endtask : t_reset
   task automatic t_codes;
      link.sel(3'h0, 4'h1);
      for (int i = 0; i < 4; i++) begin
         tpa_p[1] <= i[0];
         tpa_n[1] <= i[1];
         tpb_p[1] <= i[1];
         tpb_n[1] <= i[0];
         cyc(1);
         rchk(`PSPG_OFS_LINE, {~i[0], ~i[1], ~i[1], ~i[0], 4'h8});
      end
      tpa_p <= 3'h0;
      tpa_n <= 3'h0;
      tpb_p <= 3'h0;
      tpb_n <= 3'h0;
      $display("test codes done");
   endtask : t_codes
   task automatic t_attach;
      link.sel(3'h0, 4'h0);
      link.wr(`PSPG_OFS_CTRL, 8'h10);
      link.wr(`PSPG_OFS_IRQ_EN, 8'h00);
      wired[0] <= 1'b1;
      cyc(10);
      rchk(`PSPG_OFS_LINE, 8'hF8);
      cyc(30);
      rchk(`PSPG_OFS_LINE, 8'hF4);
      rchk(`PSPG_OFS_SPEED, 8'h88);
      rchk(`PSPG_OFS_IRQ_STAT, 8'h09);
      chk({7'h00, irq_out}, 8'h00);
      link.wr(`PSPG_OFS_IRQ_EN, 8'h3F);
      cyc(2);
      chk({7'h00, irq_out}, 8'h01);
      rchk(`PSPG_OFS_CTRL, 8'h90);
      link.wr(`PSPG_OFS_IRQ_CLR, 8'h09);
      cyc(2);
      rchk(`PSPG_OFS_IRQ_STAT, 8'h00);
      chk({7'h00, irq_out}, 8'h00);
      bus_reset_in <= 1'b1;
      cyc(3);
      bus_reset_in <= 1'b0;
      cyc(2);
      link.rd(`PSPG_OFS_LINE, v);
      chk(v & 8'h04, 8'h04);
      susp[0] <= 1'b1;
      rchk(`PSPG_OFS_LINE, 8'hFC);
      susp[0] <= 1'b0;
      link.wr(`PSPG_OFS_LINE, 8'h01);
      rchk(`PSPG_OFS_LINE, 8'hFD);
      rchk(`PSPG_OFS_LINE, 8'hFD);
      chk({5'h00, dis_out}, 8'h01);
      $display("test attach done");
   endtask : t_attach
   task automatic t_beta;
      link.sel(3'h0, 4'h2);
      beta[2] <= 1'b1;
      tones[2] <= 1'b1;
      cyc(30);
      rchk(`PSPG_OFS_LINE, 8'hF8);
      spd[2] <= 1'b1;
      cyc(30);
      rchk(`PSPG_OFS_LINE, 8'hF4);
      sval[2] <= 1'b1;
      cyc(3);
      rchk(`PSPG_OFS_LINE, 8'hF6);
      child[2] <= 1'b1;
      rchk(`PSPG_OFS_LINE, 8'hFE);
      child[2] <= 1'b0;
      $display("test beta done");
   endtask : t_beta
   task automatic t_bias;
      link.sel(3'h0, 4'h1);
      bias[1] <= 1'b1;
      cyc(10);
      rchk(`PSPG_OFS_LINE, 8'hF8);
      cyc(25);
      rchk(`PSPG_OFS_LINE, 8'hFA);
      $display("test bias done");
   endtask : t_bias
   task automatic t_unimpl;
      link.sel(3'h0, 4'h3);
      for (int a = 8; a < 16; a++) begin
         rchk(a[4:0], 8'h00);
      end
      link.sel(3'h1, 4'h0);
      rchk(`PSPG_OFS_LINE, 8'h00);
      $display("test unimplemented done");
   endtask : t_unimpl
   task automatic t_hwreset;
      @(posedge clk_in);
      rst_in <= 1'b1;
      cyc(2);
      rst_in <= 1'b0;
      link.sel(3'h0, 4'h0);
      rchk(`PSPG_OFS_LINE, 8'hF8);
      chk({5'h00, dis_out}, 8'h00);
      $display("test hardware reset done");
   endtask : t_hwreset
   // ----------------------------------------
   // run control
   // ----------------------------------------
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize
   initial begin
      #(40 * 5000);
      bad_count++;
      summarize();
   end
   initial begin
      cyc(20);
      rst_in <= 1'b0;
      t_reset();
      t_codes();
      t_attach();
      t_beta();
      t_bias();
      t_unimpl();
      t_hwreset();
      summarize();
   end
endmodule : tb_port_status_page
